// ==== hw/isq_pkg.sv ====
// Shared constants and types for the interleaved SAR sequencer
package isq_pkg;
   localparam int ISQ_SECTIONS = 16;
   localparam int ISQ_SAR_W = 9;
   localparam int ISQ_CODE_W = 8;
   localparam int ISQ_TRIM_ACC_W = 12;
   localparam int ISQ_TRIM_W = 8;
   localparam int ISQ_CAL_CNT_W = 14;
   localparam int ISQ_FIFO_DEPTH = 32;

   // Per-section frame phases, zero based (phase 0 is the first cycle)
   localparam logic [3:0] ISQ_PH_REF_ZERO = 4'h0;
   localparam logic [3:0] ISQ_PH_AUTO_ZERO = 4'h1;
   localparam logic [3:0] ISQ_PH_AUTO_CAL = 4'h2;
   localparam logic [3:0] ISQ_PH_SAMPLE = 4'h3;
   localparam logic [3:0] ISQ_PH_SAR_FIRST = 4'h4;
   localparam logic [3:0] ISQ_PH_SAR_BIT0 = 4'hc;
   localparam logic [3:0] ISQ_PH_SAR_LAST = 4'he;
   localparam logic [3:0] ISQ_PH_XFER = 4'hf;

   localparam logic [ISQ_SAR_W-1:0] ISQ_SAR_START = 9'h100;
   localparam logic [ISQ_SAR_W-1:0] ISQ_SAR_RST = 9'h000;
   localparam logic [ISQ_TRIM_ACC_W-1:0] ISQ_TRIM_RST = 12'h800;
   localparam logic [ISQ_TRIM_ACC_W-1:0] ISQ_TRIM_MAX = 12'hfff;
   localparam logic [ISQ_CODE_W-1:0] ISQ_CODE_FULL = 8'hff;
   localparam logic [3:0] ISQ_CNT_RST = 4'h0;
   localparam logic [1:0] ISQ_OE_SYNC_RST = 2'h3;
   localparam logic [ISQ_CAL_CNT_W-1:0] ISQ_CAL_CNT_RST = 14'h0000;
   localparam int ISQ_CAL_MIN_CYCLES = 10000;

   typedef enum logic [1:0] {
      ISQ_CALIBRATING = 2'b01,
      ISQ_RUNNING = 2'b10
   } isq_cal_st_t;

   typedef struct packed {
      logic overrange_flag;
      logic [ISQ_CODE_W-1:0] sample_code_bits;
   } isq_word_t;

   typedef struct packed {
      logic [3:0] cnt;
      logic [ISQ_SECTIONS-1:0][ISQ_SAR_W-1:0] sar;
      logic [ISQ_SECTIONS-1:0][ISQ_TRIM_ACC_W-1:0] az;
      logic [ISQ_SECTIONS-1:0][ISQ_TRIM_ACC_W-1:0] gc;
      logic [1:0] oe_sync;
      logic [ISQ_CAL_CNT_W-1:0] cal_cnt;
      isq_cal_st_t cal_st;
      isq_word_t out_word;
      logic out_valid;
   } isq_state_t;

   localparam isq_state_t ISQ_STATE_RST = '{
      cnt: ISQ_CNT_RST,
      sar: {ISQ_SECTIONS{ISQ_SAR_RST}},
      az: {ISQ_SECTIONS{ISQ_TRIM_RST}},
      gc: {ISQ_SECTIONS{ISQ_TRIM_RST}},
      oe_sync: ISQ_OE_SYNC_RST,
      cal_cnt: ISQ_CAL_CNT_RST,
      cal_st: ISQ_CALIBRATING,
      out_word: '0,
      out_valid: 1'b0
   };
endpackage : isq_pkg

// ==== hw/isq_sequencer.sv ====
// Interleaved SAR sequencer: phase generator, section logic, calibration loops, output mux and FIFO
`timescale 1ns/1ps
`default_nettype none

module isq_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } isq_fifo_state_t;

   isq_fifo_state_t r;
   isq_fifo_state_t n;
   logic full;
   logic empty;

   assign empty = (r.wp == r.rp);
   assign full = (r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]);
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = r.mem[r.rp[AW-1:0]];

   always_comb begin
      n = r;
      if (i_in_valid && !full) begin
         n.mem[r.wp[AW-1:0]] = i_in_data;
         n.wp = r.wp + 1'b1;
      end
      if (i_out_ready && !empty) begin
         n.rp = r.rp + 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule : isq_fifo

module isq_sequencer
   import isq_pkg::*;
#(
   parameter int CAL_MIN_CYCLES = ISQ_CAL_MIN_CYCLES,
   parameter int FIFO_DEPTH = ISQ_FIFO_DEPTH
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [ISQ_SECTIONS-1:0] i_cmp,
   input wire logic i_output_enable_n,
   input wire logic i_word_ready,
   output logic [ISQ_SECTIONS-1:0] o_ref_zero,
   output logic [ISQ_SECTIONS-1:0] o_cal_ref,
   output logic [ISQ_SECTIONS-1:0] o_sample_gate,
   output logic [ISQ_SECTIONS-1:0][ISQ_SAR_W-1:0] o_dac_code,
   output logic [ISQ_SECTIONS-1:0][ISQ_TRIM_W-1:0] o_offset_trim,
   output logic [ISQ_SECTIONS-1:0][ISQ_TRIM_W-1:0] o_gain_trim,
   output logic [ISQ_CODE_W-1:0] o_sample_code_bits,
   output logic o_overrange_flag,
   output logic o_data_oe,
   output logic o_word_valid,
   output logic o_fifo_ready,
   output logic o_word_lost,
   output logic o_cal_done
);
   isq_state_t r;
   isq_state_t n;
   isq_word_t new_word;
   isq_word_t fifo_head;
   logic [3:0] xfer_sel;
   logic out_take;
   logic fifo_out_valid;
   logic fifo_in_ready;
   logic bypass;
   logic fifo_push;

   function automatic logic [3:0] sec_phase(input logic [3:0] cnt, input int sec);
      sec_phase = 4'(cnt - 4'(sec));
   endfunction : sec_phase

   // Comparator high means the level sits above the trim point, so step down
   function automatic logic [ISQ_TRIM_ACC_W-1:0] trim_step(input logic [ISQ_TRIM_ACC_W-1:0] acc,
                                                             input logic cmp);
      trim_step = acc;
      if (cmp && acc != '0) begin
         trim_step = acc - 1'b1;
      end else if (!cmp && acc != ISQ_TRIM_MAX) begin
         trim_step = acc + 1'b1;
      end
   endfunction : trim_step

   function automatic logic [ISQ_SAR_W-1:0] sar_step(input logic [ISQ_SAR_W-1:0] v, input logic [3:0] ph,
                                                      input logic cmp);
      logic [3:0] idx;
      idx = 4'(ISQ_PH_SAR_BIT0 - ph);
      sar_step = v;
      if (!cmp) begin
         sar_step[idx] = 1'b0;
      end
      if (idx != 4'h0) begin
         sar_step[idx - 4'h1] = 1'b1;
      end
   endfunction : sar_step

   function automatic isq_word_t correct(input logic [ISQ_SAR_W-1:0] v);
      correct.overrange_flag = v[ISQ_SAR_W-1];
      correct.sample_code_bits = v[ISQ_SAR_W-1] ? ISQ_CODE_FULL : v[ISQ_CODE_W-1:0];
   endfunction : correct

   // The section in phase 15 is one ahead of the counter
   assign xfer_sel = 4'(r.cnt - ISQ_PH_XFER);
   assign new_word = correct(r.sar[xfer_sel]);

   // Output register takes the FIFO head first; the FIFO is skipped only when empty
   assign out_take = !r.out_valid || i_word_ready;
   assign bypass = out_take && !fifo_out_valid;
   assign fifo_push = !bypass;
   assign o_word_lost = fifo_push && !fifo_in_ready;
   assign o_fifo_ready = fifo_in_ready;

   isq_fifo #(
      .WIDTH(ISQ_SAR_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_in_valid(fifo_push),
      .o_in_ready(fifo_in_ready),
      .i_in_data(new_word),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(out_take),
      .o_out_data(fifo_head)
   );

   always_comb begin
      logic [3:0] ph;
      ph = 4'h0;
      n = r;
      n.cnt = r.cnt + 4'h1;
      n.oe_sync = {r.oe_sync[0], i_output_enable_n};
      for (int s = 0; s < ISQ_SECTIONS; s++) begin
         ph = sec_phase(r.cnt, s);
         case (ph)
            ISQ_PH_AUTO_ZERO: n.az[s] = trim_step(r.az[s], i_cmp[s]);
            ISQ_PH_AUTO_CAL: n.gc[s] = trim_step(r.gc[s], i_cmp[s]);
            ISQ_PH_SAMPLE: n.sar[s] = ISQ_SAR_START;
            default: begin
               // Nine bits resolve in phases 4..12; 13 and 14 leave settling margin
               if (ph >= ISQ_PH_SAR_FIRST && ph <= ISQ_PH_SAR_BIT0) begin
                  n.sar[s] = sar_step(r.sar[s], ph, i_cmp[s]);
               end
            end
         endcase
      end
      case (r.cal_st)
         ISQ_CALIBRATING: begin
            n.cal_cnt = r.cal_cnt + 1'b1;
            if (r.cal_cnt == ISQ_CAL_CNT_W'(CAL_MIN_CYCLES - 1)) begin
               n.cal_st = ISQ_RUNNING;
            end
         end
         ISQ_RUNNING: n.cal_cnt = r.cal_cnt;
         default: n.cal_st = ISQ_CALIBRATING;
      endcase
      if (out_take) begin
         n.out_valid = 1'b1;
         n.out_word = fifo_out_valid ? fifo_head : new_word;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         r <= ISQ_STATE_RST;
      end else begin
         r <= n;
      end
   end

   for (genvar g = 0; g < ISQ_SECTIONS; g++) begin : g_sec
      assign o_ref_zero[g] = (sec_phase(r.cnt, g) == ISQ_PH_REF_ZERO);
      assign o_cal_ref[g] = (sec_phase(r.cnt, g) == ISQ_PH_AUTO_CAL);
      assign o_sample_gate[g] = (sec_phase(r.cnt, g) == ISQ_PH_SAMPLE);
      assign o_dac_code[g] = r.sar[g];
      assign o_offset_trim[g] = r.az[g][ISQ_TRIM_ACC_W-1 -: ISQ_TRIM_W];
      assign o_gain_trim[g] = r.gc[g][ISQ_TRIM_ACC_W-1 -: ISQ_TRIM_W];
   end

   assign o_sample_code_bits = r.out_word.sample_code_bits;
   assign o_overrange_flag = r.out_word.overrange_flag;
   assign o_word_valid = r.out_valid;
   assign o_data_oe = !r.oe_sync[1];
   assign o_cal_done = (r.cal_st == ISQ_RUNNING);

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);

   logic [4:0] up_cycles;
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         up_cycles <= 5'h00;
      end else if (up_cycles != 5'h1f) begin
         up_cycles <= up_cycles + 5'h01;
      end
   end

   sequence s_prep0;
      o_ref_zero[0] ##1 (!o_ref_zero[0] && !o_cal_ref[0] && !o_sample_gate[0]) ##1 o_cal_ref[0]
         ##1 o_sample_gate[0];
   endsequence

   sequence s_convert0;
      (!o_sample_gate[0] && !o_ref_zero[0]) [*8] ##4 (!o_sample_gate[0] && !o_ref_zero[0]) ##1 o_ref_zero[0];
   endsequence

   a_frame_order: assert property (o_ref_zero[0] |-> s_prep0 ##1 s_convert0)
      else $error("section frame order or length wrong");

   a_one_sampler: assert property ($onehot(o_sample_gate))
      else $error("not exactly one section sampling");

   a_pattern_repeat: assert property (up_cycles > 5'd16 |->
      (o_sample_gate == $past(o_sample_gate, 16) && o_cal_ref == $past(o_cal_ref, 16)))
      else $error("timing pattern did not repeat after sixteen cycles");

   a_latency_twelve: assert property (up_cycles > 5'd12 |->
      xfer_sel == 4'($past(r.cnt, 12) - ISQ_PH_SAMPLE))
      else $error("transferred section is not the one sampled twelve cycles ago");

   a_bypass_word: assert property (bypass |=>
      (o_word_valid && {o_overrange_flag, o_sample_code_bits} == $past(new_word)))
      else $error("output register missed the mux word");

   a_overrange_ones: assert property (o_overrange_flag |-> o_sample_code_bits == ISQ_CODE_FULL)
      else $error("code bits not all ones under overrange");

   a_oe_follow: assert property (up_cycles > 5'd2 |-> o_data_oe == !$past(i_output_enable_n, 2))
      else $error("output enable did not follow its pin");

   a_sar_start: assert property (o_sample_gate[0] |=>
      r.sar[0] == ISQ_SAR_START ##1 r.sar[0][8] == $past(i_cmp[0]))
      else $error("approximation did not start or decide the top bit");

   a_zero_loop: assert property (
      (sec_phase(r.cnt, 0) == ISQ_PH_AUTO_ZERO && i_cmp[0] && r.az[0] != '0)
      |=> r.az[0] == $past(r.az[0]) - 1'b1)
      else $error("auto-zero trim did not step down");

   a_gain_loop: assert property (
      (sec_phase(r.cnt, 0) == ISQ_PH_AUTO_CAL && !i_cmp[0] && r.gc[0] != ISQ_TRIM_MAX)
      |=> r.gc[0] == $past(r.gc[0]) + 1'b1)
      else $error("gain trim did not step up");
endmodule : isq_sequencer

`default_nettype wire

// ==== sim/isq_capture_model.sv ====
// Downstream capture logic model that takes parallel sample words
`timescale 1ns/1ps
`default_nettype none

module isq_capture_model
   import isq_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_stall,
   input wire logic i_word_valid,
   input wire logic i_data_oe,
   input wire isq_word_t i_word,
   output logic o_word_ready,
   output logic [15:0] o_count,
   output var isq_word_t o_last_word
);
   // Ready only moves just after an edge; a stall shows one edge late
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_word_ready <= 1'b0;
         o_count <= 16'h0000;
         o_last_word <= '0;
      end else begin
         o_word_ready <= !i_stall;
         // Undriven outputs carry nothing worth capturing
         if (i_word_valid && o_word_ready && i_data_oe) begin
            o_count <= o_count + 16'h0001;
            o_last_word <= i_word;
         end
      end
   end
endmodule : isq_capture_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking testbench for the interleaved SAR sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import isq_pkg::*;
   localparam int CAL_N = 20;
   logic i_mclk = 1'b0;
   logic i_nrst = 1'b1;
   logic [ISQ_SECTIONS-1:0] i_cmp = '0;
   logic i_output_enable_n = 1'b0;
   logic i_word_ready;
   logic stall = 1'b0;
   logic az_bias = 1'b0;
   logic gc_bias = 1'b0;
   logic [ISQ_SECTIONS-1:0] o_ref_zero, o_cal_ref, o_sample_gate;
   logic [ISQ_SECTIONS-1:0][ISQ_SAR_W-1:0] o_dac_code;
   logic [ISQ_SECTIONS-1:0][ISQ_TRIM_W-1:0] o_offset_trim, o_gain_trim;
   logic [ISQ_CODE_W-1:0] o_sample_code_bits;
   logic o_overrange_flag, o_data_oe, o_word_valid, o_fifo_ready, o_word_lost, o_cal_done;
   logic [15:0] cap_count;
   isq_word_t cap_word;
   logic [ISQ_SAR_W-1:0] tgt [ISQ_SECTIONS];
   int hist [14];
   int err_count = 0;
   int total_checks = 0;

   // Never stopped, calibration depends on a running clock
   always #12.5 i_mclk = ~i_mclk;

   isq_sequencer #(.CAL_MIN_CYCLES(CAL_N), .FIFO_DEPTH(ISQ_FIFO_DEPTH)) isq_sequencer_inst (
      .i_mclk, .i_nrst, .i_cmp, .i_output_enable_n, .i_word_ready, .o_ref_zero, .o_cal_ref,
      .o_sample_gate, .o_dac_code, .o_offset_trim, .o_gain_trim, .o_sample_code_bits,
      .o_overrange_flag, .o_data_oe, .o_word_valid, .o_fifo_ready, .o_word_lost, .o_cal_done);

   isq_capture_model isq_capture_model_inst (
      .i_mclk, .i_nrst, .i_stall(stall), .i_word_valid(o_word_valid), .i_data_oe(o_data_oe),
      .i_word({o_overrange_flag, o_sample_code_bits}), .o_word_ready(i_word_ready), .o_count(cap_count),
      .o_last_word(cap_word));

   // Comparator stand-in: trims follow the bias knobs, SAR trials compare against each target
   always @(posedge i_mclk) begin
      int g;
      #1;
      g = 0;
      for (int s = 0; s < ISQ_SECTIONS; s++) begin
         if (o_sample_gate[s]) g = s;
      end
      for (int i = 13; i > 0; i--) hist[i] = hist[i-1];
      hist[0] = g;
      for (int s = 0; s < ISQ_SECTIONS; s++) begin
         if (s == (g + 2) % 16) i_cmp[s] = az_bias;
         else if (s == (g + 1) % 16) i_cmp[s] = gc_bias;
         else i_cmp[s] = (o_dac_code[s] <= tgt[s]);
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask : tick

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test

   task automatic test_reset();
      foreach (tgt[s]) tgt[s] = '0;
      i_nrst = 1'b0;
      tick(16);
      chk("offset trim", 16'h0080, 16'(o_offset_trim[7]));
      chk("gain trim", 16'h0080, 16'(o_gain_trim[7]));
      chk("data oe", 16'h0000, 16'(o_data_oe));
      chk("sample gate", 16'h2000, o_sample_gate);
      i_nrst = 1'b1;
      tick(2);
      chk("cal done", 16'h0000, 16'(o_cal_done));
      $display("test reset done");
   endtask : test_reset

   task automatic test_oe();
      tick(2);
      chk("data oe", 16'h0001, 16'(o_data_oe));
      i_output_enable_n = 1'b1;
      tick(1);
      chk("data oe", 16'h0001, 16'(o_data_oe));
      tick(1);
      chk("data oe", 16'h0000, 16'(o_data_oe));
      i_output_enable_n = 1'b0;
      tick(2);
      chk("data oe", 16'h0001, 16'(o_data_oe));
      $display("test output enable done");
   endtask : test_oe

   // Targets must stay put for a full frame before words are judged
   task automatic test_stream(input logic [ISQ_SAR_W-1:0] base, input logic [ISQ_SAR_W-1:0] step);
      logic [ISQ_SAR_W-1:0] t;
      logic [ISQ_SECTIONS-1:0] prev;
      logic [15:0] e;
      logic [15:0] e_prev;
      int k;
      for (int s = 0; s < ISQ_SECTIONS; s++) tgt[s] = base + step * 9'(s);
      tick(32);
      prev = o_sample_gate;
      k = 0;
      e_prev = 16'h0000;
      chk("word valid", 16'h0001, 16'(o_word_valid));
      repeat (32) begin
         tick(1);
         #1;
         t = tgt[hist[13]];
         e = t[8] ? 16'h01ff : 16'(t);
         chk("output word", e, 16'({o_overrange_flag, o_sample_code_bits}));
         // Capture at this edge took the word judged one pass earlier
         if (k > 0) chk("captured word", e_prev, 16'(cap_word));
         chk("gate step", {prev[14:0], prev[15]}, o_sample_gate);
         chk("gates open", 16'h0001, 16'($countones(o_sample_gate)));
         chk("ref zero", {o_sample_gate[12:0], o_sample_gate[15:13]}, o_ref_zero);
         chk("cal ref", {o_sample_gate[14:0], o_sample_gate[15]}, o_cal_ref);
         prev = o_sample_gate;
         e_prev = e;
         k++;
      end
      $display("test stream %h done", base);
   endtask : test_stream

   task automatic test_cal();
      az_bias = 1'b1;
      i_nrst = 1'b0;
      tick(16);
      i_nrst = 1'b1;
      tick(CAL_N - 2);
      chk("cal done", 16'h0000, 16'(o_cal_done));
      tick(4);
      chk("cal done", 16'h0001, 16'(o_cal_done));
      tick(128 - CAL_N - 2);
      for (int s = 0; s < ISQ_SECTIONS; s++) begin
         chk("offset trim", 16'h007f, 16'(o_offset_trim[s]));
         chk("gain trim", 16'h0080, 16'(o_gain_trim[s]));
      end
      az_bias = 1'b0;
      $display("test calibration done");
   endtask : test_cal

   // A full buffer refuses a push even while popping, so one slot frees and the fill then holds
   task automatic test_fifo();
      int n;
      logic [15:0] c0;
      stall = 1'b1;
      tick(1);
      c0 = cap_count;
      n = 0;
      while (o_fifo_ready && n < 40) begin
         tick(1);
         n++;
      end
      chk("edges to full", 16'(ISQ_FIFO_DEPTH), 16'(n));
      if (n >= 40) end_of_test();
      chk("word lost", 16'h0001, 16'(o_word_lost));
      chk("capture count", c0, cap_count);
      stall = 1'b0;
      tick(2);
      chk("word lost", 16'h0000, 16'(o_word_lost));
      chk("capture count", c0 + 16'h0001, cap_count);
      chk("fifo ready", 16'h0001, 16'(o_fifo_ready));
      $display("test fifo done");
   endtask : test_fifo

   initial begin
      test_reset();
      test_oe();
      test_stream(9'h000, 9'h011);
      test_stream(9'h0f8, 9'h001);
      test_stream(9'h1f0, 9'h001);
      test_cal();
      test_fifo();
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
